// ===== rtl/tdl_map.svh
`ifndef TDL_MAP_SVH
`define TDL_MAP_SVH

// ----------------------------------------
// Slave addresses and table pages
// ----------------------------------------
`define TDL_SLAVE_AUX 8'hA0
`define TDL_SLAVE_MAIN 8'hA2
`define TDL_PAGE_CTRL 8'h02
`define TDL_PAGE_APC 8'h06
`define TDL_PAGE_DAC1 8'h07
`define TDL_PAGE_DAC2 8'h08

// ----------------------------------------
// Offsets inside a lookup table page
// ----------------------------------------
`define TDL_LUT_FIRST 8'h80
`define TDL_LUT_LAST 8'hA3
`define TDL_RSVD_FIRST 8'hA4
`define TDL_RSVD_LAST 8'hA7

// ----------------------------------------
// Offsets inside the control page
// ----------------------------------------
`define TDL_CTRL_MODE 8'h80
`define TDL_CTRL_TEMPERATURE_TABLE_INDEX 8'h81
`define TDL_CTRL_LVL1_HI 8'h84
`define TDL_CTRL_LVL1_LO 8'h85
`define TDL_CTRL_LVL2_HI 8'h86
`define TDL_CTRL_LVL2_LO 8'h87

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TDL_MODE_DAC1_BIT 0
`define TDL_MODE_DAC2_BIT 1
`define TDL_MODE_RESET 8'h00
`define TDL_NV_DEFAULT 8'h00
`define TDL_LEVEL_RESET 16'h0000

// ----------------------------------------
// Temperature banding
// ----------------------------------------
`define TDL_TEMP_MIN_C 40
`define TDL_TEMP_STEP_SHIFT 2
`define TDL_LUT_ENTRIES 36
`define TDL_RSVD_ENTRIES 4

`endif

// ===== rtl/tdl_pkg.sv
package tdl_pkg;

  typedef struct packed {
    logic level_two_password_ok;
    logic level_one_password_ok;
    logic dac_tables_rw_grant;
    logic dac_tables_read_grant;
    logic control_tables_rw_grant;
    logic control_tables_read_grant;
    logic aux_memory_write_grant;
    logic aux_memory_read_grant;
  } tdl_grant_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] slave;
    logic [7:0] page;
    logic [7:0] offset;
    logic [7:0] wdata;
  } tdl_req_s;

  typedef struct packed {
    logic read_ok;
    logic write_ok;
  } tdl_perm_s;

  typedef enum logic [2:0] {
    TDL_TGT_NONE,
    TDL_TGT_AUX,
    TDL_TGT_CTRL,
    TDL_TGT_APC,
    TDL_TGT_DAC1,
    TDL_TGT_DAC2
  } tdl_target_e;

  typedef enum logic [1:0] {
    TDL_ST_IDLE,
    TDL_ST_LOAD
  } tdl_state_e;

  // Read allowed by top password, or lower password with either grant
  function automatic logic tdl_read_ok(input logic pw2, input logic pw1, input logic rw, input logic rd);
    tdl_read_ok = pw2 | (pw1 & rw) | (pw1 & rd);
  endfunction : tdl_read_ok

  function automatic logic tdl_write_ok(input logic pw2, input logic pw1, input logic rw);
    tdl_write_ok = pw2 | (pw1 & rw);
  endfunction : tdl_write_ok

endpackage : tdl_pkg

// ===== rtl/tdl_index.sv
`timescale 1ns/1ps
`include "tdl_map.svh"

module tdl_index import tdl_pkg::*; #(
  parameter int TEMP_W = 16,
  parameter int INDEX_W = 6
) (
  input wire logic [TEMP_W-1:0] temp_value,
  output logic [INDEX_W-1:0] index
);

  // ----------------------------------------
  // Band select
  // ----------------------------------------
  // Whole degrees sit in the upper byte; fraction ignored so a band edge
  // belongs to the band above it.
  wire logic signed [9:0] whole_deg = $signed({{2{temp_value[TEMP_W-1]}}, temp_value[TEMP_W-1 -: 8]});
  wire logic signed [9:0] offset_deg = whole_deg + 10'sd`TDL_TEMP_MIN_C;
  wire logic [7:0] band = 8'(offset_deg[9:`TDL_TEMP_STEP_SHIFT]);
  wire logic below = offset_deg[9];
  wire logic above = !below && (band > 8'(`TDL_LUT_ENTRIES - 1));

  assign index = below ? '0 : above ? INDEX_W'(`TDL_LUT_ENTRIES - 1) : INDEX_W'(band);

endmodule : tdl_index

// ===== rtl/tdl_grant.sv
`timescale 1ns/1ps
`include "tdl_map.svh"

module tdl_grant import tdl_pkg::*; (
  input tdl_grant_s grants,
  input tdl_target_e target,
  output tdl_perm_s perm
);

  // ----------------------------------------
  // Per-target access decode
  // ----------------------------------------
  wire logic dac_rd = tdl_read_ok(grants.level_two_password_ok, grants.level_one_password_ok,
    grants.dac_tables_rw_grant, grants.dac_tables_read_grant);
  wire logic dac_wr = tdl_write_ok(grants.level_two_password_ok, grants.level_one_password_ok,
    grants.dac_tables_rw_grant);
  wire logic ctl_rd = tdl_read_ok(grants.level_two_password_ok, grants.level_one_password_ok,
    grants.control_tables_rw_grant, grants.control_tables_read_grant);
  wire logic ctl_wr = tdl_write_ok(grants.level_two_password_ok, grants.level_one_password_ok,
    grants.control_tables_rw_grant);
  wire logic aux_rd = tdl_read_ok(grants.level_two_password_ok, grants.level_one_password_ok,
    grants.aux_memory_write_grant, grants.aux_memory_read_grant);
  wire logic aux_wr = tdl_write_ok(grants.level_two_password_ok, grants.level_one_password_ok,
    grants.aux_memory_write_grant);

  always_comb begin
    case (target)
      TDL_TGT_AUX: perm = '{read_ok: aux_rd, write_ok: aux_wr};
      TDL_TGT_CTRL, TDL_TGT_APC: perm = '{read_ok: ctl_rd, write_ok: ctl_wr};
      TDL_TGT_DAC1, TDL_TGT_DAC2: perm = '{read_ok: dac_rd, write_ok: dac_wr};
      default: perm = '{read_ok: 1'b0, write_ok: 1'b0};
    endcase
  end

endmodule : tdl_grant

// ===== rtl/tdl_bank.sv
`timescale 1ns/1ps
`include "tdl_map.svh"


module tdl_bank import tdl_pkg::*; #(
  parameter int TEMP_W = 16,
  parameter int INDEX_W = 6,
  parameter int AUX_DEPTH = 256
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input tdl_req_s req,
  input tdl_grant_s grants,
  input wire logic [TEMP_W-1:0] temp_value,
  input wire logic conversion_done,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_denied,
  output logic [15:0] first_dac_level,
  output logic [15:0] second_dac_level,
  output logic [INDEX_W-1:0] temperature_table_index,
  output logic first_dac_manual_select,
  output logic second_dac_manual_select
);

  localparam int TBL_DEPTH = `TDL_LUT_ENTRIES + `TDL_RSVD_ENTRIES;

  // ----------------------------------------
  // Nonvolatile arrays
  // ----------------------------------------
  // Kept out of reset: contents model EE and must survive a reset.
  // Factory image set at declaration, so the write processes stay the only writers
  logic [7:0] first_table [TBL_DEPTH] = '{default: `TDL_NV_DEFAULT};
  logic [7:0] second_table [TBL_DEPTH] = '{default: `TDL_NV_DEFAULT};
  logic [7:0] apc_reserved [`TDL_RSVD_ENTRIES] = '{default: `TDL_NV_DEFAULT};
  logic [7:0] aux_memory [AUX_DEPTH] = '{default: `TDL_NV_DEFAULT};

  // ----------------------------------------
  // Volatile state
  // ----------------------------------------
  logic [7:0] mode_reg;
  logic [INDEX_W-1:0] index_reg;
  logic [15:0] level1;
  logic [15:0] level2;
  tdl_state_e state;
  tdl_state_e next_state;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic is_aux = req.slave == `TDL_SLAVE_AUX;
  wire logic is_main = req.slave == `TDL_SLAVE_MAIN;
  wire logic in_table = (req.offset >= `TDL_LUT_FIRST) && (req.offset <= `TDL_RSVD_LAST);
  wire logic in_rsvd = (req.offset >= `TDL_RSVD_FIRST) && (req.offset <= `TDL_RSVD_LAST);
  wire logic pg_ctrl = is_main && req.page == `TDL_PAGE_CTRL;
  wire logic pg_apc = is_main && req.page == `TDL_PAGE_APC && in_rsvd;
  wire logic pg_dac1 = is_main && req.page == `TDL_PAGE_DAC1 && in_table;
  wire logic pg_dac2 = is_main && req.page == `TDL_PAGE_DAC2 && in_table;
  wire logic [5:0] tbl_slot = 6'(req.offset - `TDL_LUT_FIRST);
  wire logic [1:0] rsvd_slot = 2'(req.offset - `TDL_RSVD_FIRST);
  wire logic ctl_mode = pg_ctrl && req.offset == `TDL_CTRL_MODE;
  wire logic ctl_tidx = pg_ctrl && req.offset == `TDL_CTRL_TEMPERATURE_TABLE_INDEX;
  wire logic ctl_l1hi = pg_ctrl && req.offset == `TDL_CTRL_LVL1_HI;
  wire logic ctl_l1lo = pg_ctrl && req.offset == `TDL_CTRL_LVL1_LO;
  wire logic ctl_l2hi = pg_ctrl && req.offset == `TDL_CTRL_LVL2_HI;
  wire logic ctl_l2lo = pg_ctrl && req.offset == `TDL_CTRL_LVL2_LO;
  wire logic ctl_hit = ctl_mode | ctl_tidx | ctl_l1hi | ctl_l1lo | ctl_l2hi | ctl_l2lo;

  tdl_target_e target;
  assign target = is_aux ? TDL_TGT_AUX :
                  pg_dac1 ? TDL_TGT_DAC1 :
                  pg_dac2 ? TDL_TGT_DAC2 :
                  pg_apc ? TDL_TGT_APC :
                  ctl_hit ? TDL_TGT_CTRL : TDL_TGT_NONE;

  tdl_perm_s perm;

  tdl_grant u_grant (
    .grants(grants),
    .target(target),
    .perm(perm)
  );

  // ----------------------------------------
  // Temperature index
  // ----------------------------------------
  logic [INDEX_W-1:0] new_index;

  tdl_index #(
    .TEMP_W(TEMP_W),
    .INDEX_W(INDEX_W)
  ) u_index (
    .temp_value(temp_value),
    .index(new_index)
  );

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  // A host access stalls (req_ready low) in the load cycle; the load cycle owns the level registers,
  // so a host access lands one cycle later while a load is in flight.
  assign req_ready = clk_en && state == TDL_ST_IDLE;
  wire logic take = req.valid && req_ready;
  wire logic wr_go = take && req.write && perm.write_ok;
  wire logic rd_go = take && !req.write && perm.read_ok;
  wire logic manual1 = mode_reg[`TDL_MODE_DAC1_BIT];
  wire logic manual2 = mode_reg[`TDL_MODE_DAC2_BIT];
  // Level bytes are writable only in manual mode
  wire logic lvl_wr_blocked = (ctl_l1hi | ctl_l1lo) && !manual1 || (ctl_l2hi | ctl_l2lo) && !manual2;
  wire logic wr_done = wr_go && !ctl_tidx && !lvl_wr_blocked;

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  logic [7:0] read_byte;
  always_comb begin
    read_byte = 8'h00;
    case (target)
      TDL_TGT_AUX: read_byte = aux_memory[req.offset];
      TDL_TGT_DAC1: read_byte = first_table[tbl_slot];
      TDL_TGT_DAC2: read_byte = second_table[tbl_slot];
      TDL_TGT_APC: read_byte = apc_reserved[rsvd_slot];
      TDL_TGT_CTRL: begin
        if (ctl_mode) begin
          read_byte = mode_reg;
        end else if (ctl_tidx) begin
          read_byte = 8'(index_reg);
        end else if (ctl_l1hi) begin
          read_byte = level1[15:8];
        end else if (ctl_l1lo) begin
          read_byte = level1[7:0];
        end else if (ctl_l2hi) begin
          read_byte = level2[15:8];
        end else begin
          read_byte = level2[7:0];
        end
      end
      default: read_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      TDL_ST_IDLE: begin
        if (conversion_done) begin
          next_state = TDL_ST_LOAD;
        end
      end
      TDL_ST_LOAD: next_state = TDL_ST_IDLE;
      default: next_state = TDL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= TDL_ST_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      index_reg <= '0;
    end else if (clk_en && state == TDL_ST_IDLE && conversion_done) begin
      index_reg <= new_index;
    end
  end

  // ----------------------------------------
  // Level registers
  // ----------------------------------------
  wire logic load_cycle = clk_en && state == TDL_ST_LOAD;
  wire logic [15:0] table1_level = {8'h00, first_table[index_reg]};
  wire logic [15:0] table2_level = {8'h00, second_table[index_reg]};

  always_ff @(posedge clk) begin
    if (reset) begin
      level1 <= `TDL_LEVEL_RESET;
    end else if (load_cycle && !manual1) begin
      level1 <= table1_level;
    end else if (wr_done && ctl_l1hi) begin
      level1[15:8] <= req.wdata;
    end else if (wr_done && ctl_l1lo) begin
      level1[7:0] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level2 <= `TDL_LEVEL_RESET;
    end else if (load_cycle && !manual2) begin
      level2 <= table2_level;
    end else if (wr_done && ctl_l2hi) begin
      level2[15:8] <= req.wdata;
    end else if (wr_done && ctl_l2lo) begin
      level2[7:0] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg <= `TDL_MODE_RESET;
    end else if (wr_done && ctl_mode) begin
      mode_reg <= req.wdata;
    end
  end

  // ----------------------------------------
  // Nonvolatile writes
  // ----------------------------------------
  // Writes commit in one cycle; EE programming time is not modelled.
  always_ff @(posedge clk) begin
    if (wr_done && target == TDL_TGT_DAC1) begin
      first_table[tbl_slot] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_done && target == TDL_TGT_DAC2) begin
      second_table[tbl_slot] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_done && target == TDL_TGT_APC) begin
      apc_reserved[rsvd_slot] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_done && target == TDL_TGT_AUX) begin
      aux_memory[req.offset] <= req.wdata;
    end
  end

  // ----------------------------------------
  // Response
  // ----------------------------------------
  // Refused reads return zero so no protected byte leaks onto the bus.
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_denied <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= take;
      rsp_data <= rd_go ? read_byte : 8'h00;
      rsp_denied <= take && !(req.write ? wr_done : rd_go);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign first_dac_level = level1;
  assign second_dac_level = level2;
  assign temperature_table_index = index_reg;
  assign first_dac_manual_select = manual1;
  assign second_dac_manual_select = manual2;

endmodule : tdl_bank

// ===== verification/tdl_bank_asserts.sv
`timescale 1ns/1ps
`include "tdl_map.svh"

module tdl_bank_asserts import tdl_pkg::*; #(
  parameter int TEMP_W = 16,
  parameter int INDEX_W = 6
) (
  input wire logic clk,
  input wire logic reset,
  input tdl_req_s req,
  input tdl_grant_s grants,
  input wire logic [TEMP_W-1:0] temp_value,
  input wire logic conversion_done,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_denied,
  input wire logic [15:0] first_dac_level,
  input wire logic [15:0] second_dac_level,
  input wire logic [INDEX_W-1:0] temperature_table_index,
  input wire logic first_dac_manual_select,
  input wire logic second_dac_manual_select
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic signed [9:0] rel;
  logic [INDEX_W-1:0] band;
  logic go;
  logic wr_go;
  logic rd_go;
  assign rel = $signed(temp_value[15:8]) + 10'sh028;
  // Below the table or past its top: clamp
  assign band = rel[9] ? '0 : (rel > 10'sh08F ? INDEX_W'(8'h23) : INDEX_W'(rel[7:2]));
  assign go = conversion_done & req_ready;
  assign wr_go = req.valid & req_ready & req.write;
  assign rd_go = req.valid & req_ready & ~req.write;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_band;
    go |=> temperature_table_index == $past(band);
  endproperty
  a_band: assert property (p_band) else $error("index is not the temperature band");
  property p_range;
    temperature_table_index <= INDEX_W'(8'h23);
  endproperty
  a_range: assert property (p_range) else $error("index beyond last entry");
  property p_idx_hold;
    !go |=> $stable(temperature_table_index);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index moved without conversion");
  property p_hold1;
    !conversion_done && !$past(conversion_done) && !wr_go |=> $stable(first_dac_level);
  endproperty
  a_hold1: assert property (p_hold1) else $error("first level moved between loads");
  property p_man1;
    first_dac_manual_select && go && !req.valid |=> $stable(first_dac_level) [*2];
  endproperty
  a_man1: assert property (p_man1) else $error("first level loaded in manual mode");
  property p_man2;
    second_dac_manual_select && go && !req.valid |=> $stable(second_dac_level) [*2];
  endproperty
  a_man2: assert property (p_man2) else $error("second level loaded in manual mode");
  property p_load2;
    go && !second_dac_manual_select |-> ##2 second_dac_level[15:8] == 8'h00;
  endproperty
  a_load2: assert property (p_load2) else $error("second level high byte not zero");
  property p_deny;
    rd_go && req.slave == `TDL_SLAVE_MAIN && req.page == `TDL_PAGE_DAC1
      && !grants.level_two_password_ok && !grants.level_one_password_ok
      |=> rsp_valid && rsp_denied && rsp_data == 8'h00;
  endproperty
  a_deny: assert property (p_deny) else $error("table read without password");
  property p_aux;
    wr_go && req.slave == `TDL_SLAVE_AUX && grants.level_two_password_ok |=> rsp_valid && !rsp_denied;
  endproperty
  a_aux: assert property (p_aux) else $error("user memory write refused");
endmodule : tdl_bank_asserts

bind tdl_bank tdl_bank_asserts #(.TEMP_W(TEMP_W), .INDEX_W(INDEX_W)) u_asserts (
  .clk, .reset, .req, .grants, .temp_value, .conversion_done, .req_ready, .rsp_valid, .rsp_data,
  .rsp_denied, .first_dac_level, .second_dac_level, .temperature_table_index,
  .first_dac_manual_select, .second_dac_manual_select
);

// ===== verification/tdl_host.sv
`timescale 1ns/1ps

module tdl_host import tdl_pkg::*; (
  input wire logic clk,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_denied,
  output tdl_req_s req,
  output tdl_grant_s grants
);
  initial begin
    req = '0;
    grants = '0;
  end

  task automatic set_grants(input tdl_grant_s g);
    @(negedge clk);
    grants = g;
  endtask : set_grants

  // Request held until an edge that sees ready
  task automatic access(input logic w, input logic [7:0] sl, input logic [7:0] pg, input logic [7:0] off,
                        input logic [7:0] wd, output logic [7:0] rd, output logic dn);
    int n;
    n = 0;
    @(negedge clk);
    req = '{1'b1, w, sl, pg, off, wd};
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rd = rsp_valid === 1'b1 ? rsp_data : 8'hxx;
    dn = rsp_valid === 1'b1 ? rsp_denied : 1'bx;
    // Released fields show garbage, not the old request
    req = '{1'b0, ~w, ~sl, ~pg, ~off, ~wd};
  endtask : access

  // A step of zero gives a flat table, compensation off
  task automatic fill(input logic [7:0] pg, input logic [7:0] base, input logic [7:0] step);
    logic [7:0] d;
    logic e;
    for (int k = 0; k < 36; k++) access(1'b1, 8'hA2, pg, 8'h80 + k[7:0], base + step * k[7:0], d, e);
  endtask : fill
endmodule : tdl_host

// ===== verification/tdl_bank_tb_top.sv
`timescale 1ns/1ps

module tdl_bank_tb_top import tdl_pkg::*;;
  logic clk;
  logic reset;
  logic clk_en;
  logic [15:0] temp_value;
  logic conversion_done;
  tdl_req_s req;
  tdl_grant_s grants;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_denied;
  logic [15:0] first_dac_level;
  logic [15:0] second_dac_level;
  logic [5:0] temperature_table_index;
  logic first_dac_manual_select;
  logic second_dac_manual_select;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] tv [9] = '{8'hCE, 8'hD8, 8'hDB, 8'hDC, 8'hDF, 8'h00, 8'h63, 8'h64, 8'h68};
  logic [7:0] bd [9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h0A, 8'h22, 8'h23, 8'h23};
  // Bits: top pw, lower pw, rw grant, read grant, read ok, write ok
  logic [5:0] gc [5] = '{6'h23, 6'h10, 6'h1B, 6'h16, 6'h0C};
  logic [7:0] sl [3] = '{8'hA2, 8'hA2, 8'hA0};
  logic [7:0] pg [3] = '{8'h07, 8'h08, 8'h00};
  logic [7:0] of [3] = '{8'hA5, 8'h90, 8'h3C};

  tdl_bank uut (.clk(clk), .reset(reset), .clk_en(clk_en), .req(req), .grants(grants),
    .temp_value(temp_value), .conversion_done(conversion_done), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_denied(rsp_denied), .first_dac_level(first_dac_level),
    .second_dac_level(second_dac_level), .temperature_table_index(temperature_table_index),
    .first_dac_manual_select(first_dac_manual_select), .second_dac_manual_select(second_dac_manual_select));
  tdl_host host (.clk(clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_denied(rsp_denied), .req(req), .grants(grants));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conv(input logic [7:0] deg);
    @(negedge clk);
    temp_value = {deg, 8'h5A};
    conversion_done = 1'b1;
    @(negedge clk);
    conversion_done = 1'b0;
    @(negedge clk);
  endtask : conv

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] wd;
    logic [7:0] prev;
    logic e;
    logic [5:0] c;
    reset = 1'b1;
    clk_en = 1'b1;
    temp_value = 16'h0000;
    conversion_done = 1'b0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    chk(first_dac_level, 16'h0000);
    chk(second_dac_level, 16'h0000);
    for (int t = 0; t < 3; t++) begin
      host.set_grants(8'h80);
      host.access(1'b0, sl[t], pg[t], of[t], 8'h00, d, e);
      chk(d, 8'h00);
      prev = 8'h00;
      for (int i = 0; i < 5; i++) begin
        c = gc[i];
        host.set_grants(t == 2 ? {c[5:4], 4'h0, c[3:2]} : {c[5:2], 4'h0});
        wd = {t[3:0], i[3:0]} + 8'h11;
        host.access(1'b1, sl[t], pg[t], of[t], wd, d, e);
        chk(e, !c[0]);
        if (c[0]) prev = wd;
        host.access(1'b0, sl[t], pg[t], of[t], 8'h00, d, e);
        chk(e, !c[1]);
        chk(d, c[1] ? prev : 8'h00);
      end
    end
    host.set_grants(8'h80);
    host.fill(8'h07, 8'h40, 8'h01);
    host.fill(8'h08, 8'hC0, 8'h01);
    for (int i = 0; i < 9; i++) begin
      conv(tv[i]);
      chk(temperature_table_index, bd[i]);
      chk(first_dac_level, {8'h00, 8'h40 + bd[i]});
      chk(second_dac_level, {8'h00, 8'hC0 + bd[i]});
      host.access(1'b0, 8'hA2, 8'h02, 8'h81, 8'h00, d, e);
      chk(d, bd[i]);
    end
    host.access(1'b1, 8'hA2, 8'h02, 8'h80, 8'h03, d, e);
    chk({first_dac_manual_select, second_dac_manual_select}, 2'h3);
    for (int k = 0; k < 4; k++) host.access(1'b1, 8'hA2, 8'h02, 8'h84 + k[7:0], 8'h12 + 8'h22 * k[7:0], d, e);
    conv(8'hD8);
    chk(first_dac_level, 16'h1234);
    chk(second_dac_level, 16'h5678);
    host.access(1'b1, 8'hA2, 8'h02, 8'h80, 8'h00, d, e);
    host.access(1'b1, 8'hA2, 8'h02, 8'h84, 8'h99, d, e);
    chk(e, 1'b1);
    host.access(1'b1, 8'hA2, 8'h02, 8'h81, 8'h07, d, e);
    chk(e, 1'b1);
    host.access(1'b0, 8'hA2, 8'h06, 8'h80, 8'h00, d, e);
    chk({d, 7'h00, e}, 16'h0001);
    host.set_grants(8'h48);
    host.access(1'b1, 8'hA2, 8'h06, 8'hA6, 8'h5A, d, e);
    chk(e, 1'b0);
    host.access(1'b0, 8'hA2, 8'h06, 8'hA6, 8'h00, d, e);
    chk(d, 8'h5A);
    host.set_grants(8'h70);
    host.access(1'b0, 8'hA2, 8'h06, 8'hA6, 8'h00, d, e);
    chk({d, 7'h00, e}, 16'h0001);
    host.set_grants(8'h80);
    host.fill(8'h08, 8'h66, 8'h00);
    conv(8'h30);
    chk(temperature_table_index, 6'h16);
    chk(second_dac_level, 16'h0066);
    @(negedge clk);
    clk_en = 1'b0;
    @(negedge clk);
    chk(req_ready, 1'b0);
    // Conversion while frozen must leave index and first level alone
    conv(8'h00);
    chk(temperature_table_index, 6'h16);
    chk(first_dac_level, 16'h0056);
    clk_en = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk(first_dac_level, 16'h0000);
    chk(temperature_table_index, 6'h00);
    host.access(1'b0, 8'hA2, 8'h07, 8'h81, 8'h00, d, e);
    chk(d, 8'h41);
    wrap_up();
  end
endmodule : tdl_bank_tb_top
